// *** mie_pkg.sv ***
// Purpose: shared constants for the move / indirect move execution block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   window locations alias the two pointers

package mie_pkg;

   localparam int DATA_W = 8;
   localparam int PTR_W  = 16;
   localparam int FA_W   = 7;
   localparam int OFS_W  = 6;
   localparam int PA_W   = 8;

   // addressing modes of the indirect load
   localparam logic [1:0] MODE_PRE_INC  = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;

   // file locations without storage, one per pointer
   localparam logic [6:0] WIN0_LOC = 7'h00;
   localparam logic [6:0] WIN1_LOC = 7'h01;

   // register map (byte addresses)
   localparam logic [7:0] OFS_WREG   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PTR0   = 8'h08;
   localparam logic [7:0] OFS_PTR1   = 8'h0C;
   localparam logic [7:0] OFS_CTRL   = 8'h10;

   localparam int STAT_Z_BIT  = 0;
   localparam int CTRL_EN_BIT = 0;

   localparam logic [7:0]  W_RST    = 8'h00;
   localparam logic [15:0] PTR_RST  = 16'h0000;
   localparam logic [15:0] PTR_ONE  = 16'h0001;
   localparam logic        Z_RST    = 1'b0;
   localparam logic        EN_RST   = 1'b1;

endpackage

// *** mie_move_exec.sv ***
// Purpose: executes the file copy and indirect load instructions
// Assumes: instruction fields arrive already decoded, memory read is
//          combinational within the cycle
// Notes:   APB slave exposes working register, zero flag, pointers
//
// The implementer's own choices: the APB slave port and the register addresses.

`timescale 1ns/1ps

module mie_move_exec
#(
   parameter int DATA_W = mie_pkg::DATA_W,
   parameter int PTR_W  = mie_pkg::PTR_W
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // instruction issue
   input  wire logic              op_valid,
   input  wire logic              file_copy_op,
   input  wire logic              indirect_load_op,
   input  wire logic [6:0]        file_addr,
   input  wire logic              dest_bit,
   input  wire logic              ptr_index,
   input  wire logic [1:0]        addr_mode_field,
   input  wire logic              rel_form,
   input  wire logic [5:0]        rel_offset,
   output logic                   op_done,
   // data space
   output logic [PTR_W-1:0]       dm_addr,
   input  wire logic [DATA_W-1:0] dm_rdata,
   output logic [DATA_W-1:0]      dm_wdata,
   output logic                   dm_we,
   // core state
   output logic [DATA_W-1:0]      w_out,
   output logic                   z_out,
   output logic [PTR_W-1:0]       indirect_pointer0,
   output logic [PTR_W-1:0]       indirect_pointer1,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr
);

   // wrap-around add of a signed step to a pointer
   function automatic logic [PTR_W-1:0] ptr_add
   (
      input logic [PTR_W-1:0] base,
      input logic [PTR_W-1:0] step
   );
   begin
      ptr_add = base + step;
   end
   endfunction

   // sign-extends the relative offset to pointer width
   function automatic logic [PTR_W-1:0] sext_ofs
   (
      input logic [5:0] ofs
   );
   begin
      sext_ofs = {{(PTR_W-6){ofs[5]}}, ofs};
   end
   endfunction

   logic [DATA_W-1:0] w_reg;
   logic [DATA_W-1:0] w_next;
   logic              z_reg;
   logic              z_next;
   logic [PTR_W-1:0]  ptr0_reg;
   logic [PTR_W-1:0]  ptr0_next;
   logic [PTR_W-1:0]  ptr1_reg;
   logic [PTR_W-1:0]  ptr1_next;
   logic              en_reg;
   logic              en_next;
   logic              done_reg;
   logic [31:0]       rdata_reg;
   logic              err_reg;

   // instruction qualification
   wire logic exec       = ce & en_reg & op_valid;
   wire logic do_copy    = exec & file_copy_op;
   wire logic do_iload   = exec & indirect_load_op & ~file_copy_op;

   // window detection for the file copy
   wire logic hit_win0   = (file_addr == mie_pkg::WIN0_LOC);
   wire logic hit_win1   = (file_addr == mie_pkg::WIN1_LOC);
   wire logic hit_win    = hit_win0 | hit_win1;

   // pointer chosen by the indirect load
   wire logic [PTR_W-1:0] sel_ptr = ptr_index ? ptr1_reg : ptr0_reg;

   wire logic [PTR_W-1:0] ptr_inc = ptr_add(sel_ptr, mie_pkg::PTR_ONE);
   wire logic [PTR_W-1:0] ptr_dec = ptr_add(sel_ptr, -mie_pkg::PTR_ONE);
   wire logic [PTR_W-1:0] ptr_rel = ptr_add(sel_ptr, sext_ofs(rel_offset));

   wire logic mode_inc =
      (addr_mode_field == mie_pkg::MODE_PRE_INC) |
      (addr_mode_field == mie_pkg::MODE_POST_INC);

   // effective address of the indirect load
   logic [PTR_W-1:0] iload_addr;
   always_comb
   begin
      if (rel_form)
      begin
         iload_addr = ptr_rel;
      end
      else
      begin
         unique case (addr_mode_field)
            mie_pkg::MODE_PRE_INC:  iload_addr = ptr_inc;
            mie_pkg::MODE_PRE_DEC:  iload_addr = ptr_dec;
            mie_pkg::MODE_POST_INC: iload_addr = sel_ptr;
            mie_pkg::MODE_POST_DEC: iload_addr = sel_ptr;
         endcase
      end
   end

   // pointer value after the indirect load
   wire logic [PTR_W-1:0] ptr_after =
      rel_form ? sel_ptr : (mode_inc ? ptr_inc : ptr_dec);

   // file copy address: window locations redirect through a pointer
   wire logic [PTR_W-1:0] copy_addr =
      hit_win1 ? ptr1_reg :
      hit_win0 ? ptr0_reg :
      {{(PTR_W-7){1'b0}}, file_addr};

   // data space port; address stays meaningful even when idle
   assign dm_addr  = do_iload ? iload_addr : copy_addr;
   // write back of the same value when d is 1
   assign dm_we    = do_copy & dest_bit;
   assign dm_wdata = dm_rdata;

   wire logic moved_zero = (dm_rdata == '0);

   // APB decode
   wire logic apb_wr   = psel & penable & pwrite & ce;
   // reads are captured in setup so prdata stands through the access phase
   wire logic apb_rd   = psel & ~penable & ~pwrite & ce;
   wire logic sel_w    = (paddr == mie_pkg::OFS_WREG);
   wire logic sel_stat = (paddr == mie_pkg::OFS_STATUS);
   wire logic sel_p0   = (paddr == mie_pkg::OFS_PTR0);
   wire logic sel_p1   = (paddr == mie_pkg::OFS_PTR1);
   wire logic sel_ctrl = (paddr == mie_pkg::OFS_CTRL);
   wire logic sel_any  = sel_w | sel_stat | sel_p0 | sel_p1 | sel_ctrl;

   wire logic [31:0] rd_mux =
      sel_w    ? {{(32-DATA_W){1'b0}}, w_reg} :
      sel_stat ? {31'h0000_0000, z_reg} :
      sel_p0   ? {{(32-PTR_W){1'b0}}, ptr0_reg} :
      sel_p1   ? {{(32-PTR_W){1'b0}}, ptr1_reg} :
      sel_ctrl ? {31'h0000_0000, en_reg} :
      32'h0000_0000;

   // next state: an instruction takes priority over an APB write
   always_comb
   begin
      w_next    = w_reg;
      z_next    = z_reg;
      ptr0_next = ptr0_reg;
      ptr1_next = ptr1_reg;
      en_next   = en_reg;
      if (apb_wr)
      begin
         if (sel_w)
         begin
            w_next = pwdata[DATA_W-1:0];
         end
         if (sel_stat)
         begin
            z_next = pwdata[mie_pkg::STAT_Z_BIT];
         end
         if (sel_p0)
         begin
            ptr0_next = pwdata[PTR_W-1:0];
         end
         if (sel_p1)
         begin
            ptr1_next = pwdata[PTR_W-1:0];
         end
         if (sel_ctrl)
         begin
            en_next = pwdata[mie_pkg::CTRL_EN_BIT];
         end
      end
      // an executing instruction overrides a same-edge register write
      if (do_copy)
      begin
         if (!dest_bit)
         begin
            w_next = dm_rdata;
         end
         z_next = moved_zero;
      end
      if (do_iload)
      begin
         w_next = dm_rdata;
         z_next = moved_zero;
         if (ptr_index)
         begin
            ptr1_next = ptr_after;
         end
         else
         begin
            ptr0_next = ptr_after;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         w_reg    <= mie_pkg::W_RST;
         z_reg    <= mie_pkg::Z_RST;
         ptr0_reg <= mie_pkg::PTR_RST;
         ptr1_reg <= mie_pkg::PTR_RST;
         en_reg   <= mie_pkg::EN_RST;
      end
      else if (ce)
      begin
         w_reg    <= w_next;
         z_reg    <= z_next;
         ptr0_reg <= ptr0_next;
         ptr1_reg <= ptr1_next;
         en_reg   <= en_next;
      end
   end

   // completion pulse and registered read data
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         done_reg  <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end
      else if (ce)
      begin
         done_reg  <= do_copy | do_iload;
         if (apb_rd)
         begin
            rdata_reg <= rd_mux;
         end
         err_reg   <= psel & ~penable & ~sel_any;
      end
   end

   // zero-wait when running; ce low stretches the access phase
   assign pready  = ce;
   assign prdata  = rdata_reg;
   assign pslverr = psel & penable & err_reg;

   assign op_done           = done_reg;
   assign w_out             = w_reg;
   assign z_out             = z_reg;
   assign indirect_pointer0 = ptr0_reg;
   assign indirect_pointer1 = ptr1_reg;

endmodule

// *** mie_chk.sv ***
// Purpose: port assertions for mie_move_exec
// Assumes: enable bit stays at its reset value
// Notes:   address checks watch pointer 0 only
`timescale 1ns/1ps
module mie_chk
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        op_valid,
   input wire logic        file_copy_op,
   input wire logic        indirect_load_op,
   input wire logic        dest_bit,
   input wire logic        ptr_index,
   input wire logic [1:0]  addr_mode_field,
   input wire logic        rel_form,
   input wire logic [5:0]  rel_offset,
   input wire logic        op_done,
   input wire logic [15:0] dm_addr,
   input wire logic [7:0]  dm_rdata,
   input wire logic        dm_we,
   input wire logic [7:0]  w_out,
   input wire logic        z_out,
   input wire logic [15:0] indirect_pointer0
);
   logic ld0;
   assign ld0 = ce & op_valid & indirect_load_op & ~file_copy_op & ~ptr_index;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_done; op_done |-> $past(ce & op_valid); endproperty
   a_done: assert property (p_done) else $error("stray done");
   property p_w;
      op_done && $past(~file_copy_op | ~dest_bit) |-> w_out == $past(dm_rdata);
   endproperty
   a_w: assert property (p_w) else $error("w value");
   property p_keep;
      op_done && $past(file_copy_op & dest_bit) |-> w_out == $past(w_out);
   endproperty
   a_keep: assert property (p_keep) else $error("w changed");
   property p_z; op_done |-> z_out == ($past(dm_rdata) == 8'h00); endproperty
   a_z: assert property (p_z) else $error("zero flag");
   property p_we; dm_we |-> ce && op_valid && file_copy_op && dest_bit; endproperty
   a_we: assert property (p_we) else $error("stray write");
   property p_addr;
      ld0 && !rel_form |-> dm_addr == indirect_pointer0 + (addr_mode_field[1] ?
         16'h0000 : addr_mode_field[0] ? 16'hFFFF : 16'h0001);
   endproperty
   a_addr: assert property (p_addr) else $error("address");
   property p_rel;
      ld0 && rel_form |-> dm_addr == indirect_pointer0 + {{10{rel_offset[5]}},
         rel_offset};
   endproperty
   a_rel: assert property (p_rel) else $error("offset");
   property p_upd;
      op_done && $past(ld0 & ~rel_form) |-> indirect_pointer0 ==
         $past(indirect_pointer0) + ($past(addr_mode_field[0]) ? 16'hFFFF : 16'h0001);
   endproperty
   a_upd: assert property (p_upd) else $error("pointer");
   c_rel: cover property (ld0 && rel_form);
   c_we: cover property (dm_we);
   c_zero: cover property (op_done && z_out);
endmodule
bind mie_move_exec mie_chk i_mie_chk (.*);

// *** move_and_indirect_move_exec_tb.sv ***
// Purpose: directed bench for mie_move_exec
// Assumes: memory byte is low xor high address byte
// Notes:   ce held high, enable bit never cleared
`timescale 1ns/1ps
module move_and_indirect_move_exec_tb;
   logic        clk, rst, ce, op_valid, file_copy_op, indirect_load_op;
   logic        dest_bit, ptr_index, rel_form, op_done, dm_we, z_out;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [1:0]  addr_mode_field;
   logic [5:0]  rel_offset;
   logic [6:0]  file_addr;
   logic [7:0]  paddr, dm_rdata, dm_wdata, w_out;
   logic [15:0] dm_addr, indirect_pointer0, indirect_pointer1;
   logic [31:0] pwdata, prdata;
   logic [15:0] e[2];
   int          bad_count, tests_run;
   // zeros at 0000h and FFFFh give zero-flag cases at the wrap points
   assign dm_rdata = dm_addr[7:0] ^ dm_addr[15:8];
   mie_move_exec i_mie_move_exec (.*);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic results;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      tests_run++;
      if (s !== x)
      begin
         bad_count++;
         $display("wrong value at %0t: %h, expected %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, x, input logic er);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         bad_count++;
         results;
      end
      chk(pslverr, er);
      if (!w)
         chk(prdata, x);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic go(input logic fc, input logic [6:0] fa, input logic d, pi,
                     input logic [1:0] m, input logic r, input logic [5:0] o);
      @(posedge clk);
      op_valid         <= 1'b1;
      file_copy_op     <= fc;
      indirect_load_op <= ~fc;
      file_addr        <= fa;
      dest_bit         <= d;
      ptr_index        <= pi;
      addr_mode_field  <= m;
      rel_form         <= r;
      rel_offset       <= o;
      @(posedge clk);
      chk(dm_we, fc & d);
      if (fc & d)
         chk(dm_wdata, dm_addr[7:0] ^ dm_addr[15:8]);
      op_valid <= 1'b0;
      #1 chk(op_done, 1'b1);
   endtask
   task automatic ld(input logic pi, input logic [1:0] m, input logic r,
                     input logic [5:0] o);
      logic [15:0] p, a;
      p = e[pi];
      a = r ? p + {{10{o[5]}}, o} : m == 2'h0 ? p + 16'h0001 :
          m == 2'h1 ? p - 16'h0001 : p;
      if (!r)
         e[pi] = m[0] ? p - 16'h0001 : p + 16'h0001;
      go(1'b0, 7'h00, 1'b0, pi, m, r, o);
      chk(w_out, a[7:0] ^ a[15:8]);
      chk(z_out, a[7:0] == a[15:8]);
      chk(pi ? indirect_pointer1 : indirect_pointer0, e[pi]);
   endtask
   task automatic t_regs;
      apb(1'b0, mie_pkg::OFS_CTRL, 32'h0, 32'h1, 1'b0);
      apb(1'b0, mie_pkg::OFS_PTR1, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 8'h18, 32'hFF, 32'h0, 1'b1);
      apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
   endtask
   task automatic t_load;
      apb(1'b1, mie_pkg::OFS_PTR0, 32'hFFFF, 32'h0, 1'b0);
      apb(1'b1, mie_pkg::OFS_PTR1, 32'h1234, 32'h0, 1'b0);
      e[0] = 16'hFFFF;
      e[1] = 16'h1234;
      ld(1'b0, 2'h0, 1'b0, 6'h00);
      ld(1'b0, 2'h1, 1'b0, 6'h00);
      for (int m = 0; m < 4; m++)
         ld(1'b1, m[1:0], 1'b0, 6'h00);
      ld(1'b0, 2'h0, 1'b1, 6'h20);
      ld(1'b0, 2'h3, 1'b1, 6'h1F);
   endtask
   task automatic t_copy;
      go(1'b1, 7'h22, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
      chk(w_out, 8'h22);
      chk(z_out, 1'b0);
      go(1'b1, mie_pkg::WIN0_LOC, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
      chk(w_out, 8'h22);
      chk(z_out, 1'b1);
      apb(1'b0, mie_pkg::OFS_STATUS, 32'h0, 32'h1, 1'b0);
   endtask
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      {op_valid, file_copy_op, indirect_load_op, file_addr, dest_bit} = '0;
      {ptr_index, addr_mode_field, rel_form, rel_offset} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_load;
      t_copy;
      results;
   end
endmodule
